// File: tss_top.sv
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "tss_defs.svh"
module tss_top
  import tss_pkg::*;
#(
  parameter int TICK_CYCLES = `TSS_TICK_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Panel supervision
  output logic poll_o,
  input wire logic poll_reply_i,
  // Remote programming
  input wire logic prog_fail_i,
  input wire logic prog_ok_i,
  // Hub link
  input wire logic tx_msg_i,
  input wire logic ack_i,
  input wire logic link_fault_i,
  output logic evt_valid_o,
  input wire logic evt_ready_i,
  output logic evt_restore_o,
  output logic [15:0] evt_id_o,
  output logic [15:0] evt_zone_o,
  output logic [23:0] evt_account_o,
  output logic [15:0] baud_div_o,
  output logic parity_en_o,
  output logic parity_even_o,
  output logic stop_one_o,
  output logic flow_en_o,
  // Board pins
  input wire logic factory_default_jumper_i,
  output logic factory_restore_o,
  output logic trouble_led_o,
  output logic conn_led_o
);
  // ************************************************
  // Functions
  // ************************************************
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] baud_div(input logic [2:0] code);
    unique case (code)
      3'h1: baud_div = 16'(`TSS_CLK_HZ / `TSS_BAUD1);
      3'h2: baud_div = 16'(`TSS_CLK_HZ / `TSS_BAUD2);
      3'h3: baud_div = 16'(`TSS_CLK_HZ / `TSS_BAUD3);
      3'h4: baud_div = 16'(`TSS_CLK_HZ / `TSS_BAUD4);
      default: baud_div = 16'(`TSS_CLK_HZ / `TSS_BAUD5);
    endcase
  endfunction

  // ************************************************
  // Declarations
  // ************************************************
  logic [16:0] tick_cnt;
  logic tick;
  logic wait_r;
  logic acc_wr;
  logic [6:0] ctrl;
  logic [23:0] acct;
  logic [15:0] poll_ms;
  logic [2:0] jsync;
  logic jmp_lvl;
  logic init_busy;
  logic [15:0] init_cnt;
  logic [15:0] uni_cnt;
  logic init_led;
  logic [15:0] poll_cnt;
  logic poll_due;
  logic replied;
  logic [2:0] miss;
  logic absent;
  logic absent_q;
  logic pend_t;
  logic pend_r;
  logic t_first;
  logic load;
  logic cfg_fail;
  logic mod_cfg;
  logic [3:0] flash_cnt;
  logic tled;
  logic cled;
  logic [31:0] status;

  // ************************************************
  // Millisecond tick
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b0;
    end else if (tick_cnt == 17'(TICK_CYCLES - 1)) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
      tick <= 1'b0;
    end
  end

  // ************************************************
  // Bus slave
  // ************************************************
  assign acc_wr = write_i && !wait_r;
  assign status = {20'h00000, flash_cnt, 1'b0, miss, init_busy, mod_cfg, cfg_fail, absent};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r <= 1'b1;
      readdata_o <= 32'h00000000;
    end else begin
      wait_r <= !((read_i || write_i) && wait_r);
      if (read_i && wait_r) begin
        unique case (address_i)
          `TSS_ADDR_CTRL: readdata_o <= {25'h0000000, ctrl};
          `TSS_ADDR_ACCT: readdata_o <= {8'h00, acct};
          `TSS_ADDR_POLL: readdata_o <= {16'h0000, poll_ms};
          `TSS_ADDR_STAT: readdata_o <= status;
          default: readdata_o <= 32'h00000000;
        endcase
      end
    end
  end
  assign waitrequest_o = wait_r;

  // ************************************************
  // Configuration registers
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= `TSS_CTRL_RST;
    end else if (factory_restore_o) begin
      ctrl <= `TSS_CTRL_RST;
    end else if (acc_wr && address_i == `TSS_ADDR_CTRL) begin
      ctrl <= 7'(wmerge({25'h0000000, ctrl}, writedata_i, byteenable_i));
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acct <= `TSS_ACCT_RST;
    end else if (factory_restore_o) begin
      acct <= `TSS_ACCT_RST;
    end else if (acc_wr && address_i == `TSS_ADDR_ACCT) begin
      acct <= 24'(wmerge({8'h00, acct}, writedata_i, byteenable_i));
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      poll_ms <= `TSS_POLL_RST;
    end else if (factory_restore_o) begin
      poll_ms <= `TSS_POLL_RST;
    end else if (acc_wr && address_i == `TSS_ADDR_POLL) begin
      poll_ms <= 16'(wmerge({16'h0000, poll_ms}, writedata_i, byteenable_i));
    end
  end

  // ************************************************
  // Link settings
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_div_o <= 16'h0000;
      parity_en_o <= 1'b0;
      parity_even_o <= 1'b0;
      stop_one_o <= 1'b0;
      flow_en_o <= 1'b0;
    end else begin
      baud_div_o <= baud_div(ctrl[2:0]);
      parity_en_o <= ctrl[`TSS_CTRL_PAR_EN];
      parity_even_o <= ctrl[`TSS_CTRL_PAR_EVEN];
      stop_one_o <= ctrl[`TSS_CTRL_STOP1];
      flow_en_o <= ctrl[`TSS_CTRL_FLOW];
    end
  end

  // ************************************************
  // Restart and factory default
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      jsync <= 3'h0;
      jmp_lvl <= 1'b0;
    end else begin
      jsync <= {jsync[1:0], factory_default_jumper_i};
      if (jsync[1] == jsync[2]) begin
        jmp_lvl <= jsync[2];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_busy <= 1'b1;
      init_cnt <= 16'h0000;
      factory_restore_o <= 1'b0;
    end else begin
      factory_restore_o <= 1'b0;
      if (init_busy && tick) begin
        if (init_cnt == `TSS_INIT_MS - 16'h0001) begin
          init_busy <= 1'b0;
          factory_restore_o <= jmp_lvl;
        end else begin
          init_cnt <= init_cnt + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uni_cnt <= 16'h0000;
      init_led <= 1'b1;
    end else if (tick) begin
      if (uni_cnt == `TSS_FLASH_ON_MS - 16'h0001) begin
        uni_cnt <= 16'h0000;
        init_led <= !init_led;
      end else begin
        uni_cnt <= uni_cnt + 16'h0001;
      end
    end
  end

  // ************************************************
  // Panel supervision
  // ************************************************
  assign poll_due = tick && !init_busy && ((poll_ms == 16'h0000) || (poll_cnt >= poll_ms - 16'h0001));

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      poll_cnt <= 16'h0000;
      poll_o <= 1'b0;
    end else begin
      poll_o <= poll_due;
      if (poll_due) begin
        poll_cnt <= 16'h0000;
      end else if (tick && !init_busy) begin
        poll_cnt <= poll_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      replied <= 1'b1;
      miss <= 3'h0;
      absent <= 1'b0;
    end else begin
      if (poll_due) begin
        replied <= 1'b0;
      end
      if (poll_reply_i) begin
        replied <= 1'b1;
        miss <= 3'h0;
        absent <= 1'b0;
      end else if (poll_due && !replied) begin
        if (miss != `TSS_MISS_LIMIT) begin
          miss <= miss + 3'h1;
        end
        if (miss == `TSS_MISS_LIMIT - 3'h1) begin
          absent <= 1'b1;
        end
      end
    end
  end

  // ************************************************
  // Event queue toward the hub
  // ************************************************
  assign load = (!evt_valid_o || evt_ready_i) && (pend_t || pend_r);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      absent_q <= 1'b0;
      pend_t <= 1'b0;
      pend_r <= 1'b0;
      t_first <= 1'b0;
      evt_valid_o <= 1'b0;
      evt_restore_o <= 1'b0;
      evt_id_o <= 16'h0000;
      evt_zone_o <= 16'h0000;
      evt_account_o <= 24'h000000;
    end else begin
      absent_q <= absent;
      if (evt_ready_i) begin
        evt_valid_o <= 1'b0;
      end
      if (load) begin
        evt_valid_o <= 1'b1;
        evt_zone_o <= `TSS_ZONE;
        evt_account_o <= acct;
        if (pend_t && (!pend_r || t_first)) begin
          pend_t <= 1'b0;
          evt_restore_o <= 1'b0;
          evt_id_o <= `TSS_ID_TRBL;
        end else begin
          pend_r <= 1'b0;
          evt_restore_o <= 1'b1;
          evt_id_o <= `TSS_ID_RST;
        end
      end
      if (absent && !absent_q) begin
        pend_t <= 1'b1;
        if (!pend_r) begin
          t_first <= 1'b1;
        end
      end
      if (!absent && absent_q) begin
        pend_r <= 1'b1;
        if (!pend_t) begin
          t_first <= 1'b0;
        end
      end
    end
  end

  // ************************************************
  // Trouble sources and priority
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_fail <= 1'b0;
      mod_cfg <= 1'b0;
      flash_cnt <= 4'h0;
    end else begin
      if (prog_fail_i) begin
        cfg_fail <= 1'b1;
      end else if (prog_ok_i) begin
        cfg_fail <= 1'b0;
      end
      mod_cfg <= (acct == `TSS_ACCT_ZERO) || (acct == `TSS_ACCT_RST);
      if (absent) begin
        flash_cnt <= `TSS_CNT_SUPV;
      end else if (cfg_fail) begin
        flash_cnt <= `TSS_CNT_CFG;
      end else if (mod_cfg) begin
        flash_cnt <= `TSS_CNT_MOD;
      end else begin
        flash_cnt <= 4'h0;
      end
    end
  end

  // ************************************************
  // LED drivers
  // ************************************************
  tss_flash u_flash (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .count_i(flash_cnt),
    .led_o(tled)
  );

  tss_blink u_blink (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .once_i(tx_msg_i),
    .twice_i(ack_i),
    .fault_i(link_fault_i),
    .led_o(cled)
  );

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trouble_led_o <= 1'b0;
      conn_led_o <= 1'b0;
    end else begin
      trouble_led_o <= init_busy ? init_led : tled;
      conn_led_o <= init_busy ? init_led : cled;
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  supv_rise_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(absent) |-> $past(miss) == `TSS_MISS_LIMIT - 3'h1) else $error("Supervision raised early");
  supv_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    poll_reply_i |=> !absent && miss == 3'h0) else $error("Reply did not clear trouble");
  evt_trbl_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(absent) |=> pend_t) else $error("Trouble event not queued");
  evt_rst_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(absent) |=> pend_r) else $error("Restore event not queued");
  evt_code_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    evt_valid_o |-> evt_zone_o == `TSS_ZONE && evt_id_o == (evt_restore_o ? `TSS_ID_RST : `TSS_ID_TRBL))
    else $error("Wrong event code");
  evt_acct_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(evt_valid_o) |-> evt_account_o == $past(acct)) else $error("Wrong event account");
  cfg_fail_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    prog_fail_i |=> cfg_fail ##1 flash_cnt != 4'h0) else $error("Config failure not raised");
  led_prio_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    absent |=> flash_cnt == `TSS_CNT_SUPV) else $error("Supervision not shown first");
  init_led_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    init_busy |=> trouble_led_o == conn_led_o) else $error("LEDs not in unison at init");
  jmp_late_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !init_busy |=> !factory_restore_o) else $error("Jumper acted after restart");
  baud_map_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ctrl[2:0] == 3'h1 |=> baud_div_o == 16'h32dc) else $error("Wrong divisor for 9600");
endmodule

// File: tss_defs.svh
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH
// ************************************************
// Clock and time base
// ************************************************
`define TSS_CLK_HZ 125000000
`define TSS_CLK_NS 8
`define TSS_MS_NS 1000000
`define TSS_TICK_CYC (`TSS_MS_NS / `TSS_CLK_NS)
// ************************************************
// Durations in milliseconds
// ************************************************
`define TSS_FLASH_ON_MS 16'h00fa
`define TSS_FLASH_OFF_MS 16'h00fa
`define TSS_PAUSE_MS 16'h05dc
`define TSS_BLINK_MS 16'h003c
`define TSS_INIT_MS 16'h07d0
// ************************************************
// Supervision and trouble codes
// ************************************************
`define TSS_MISS_LIMIT 3'h6
`define TSS_CNT_SUPV 4'h2
`define TSS_CNT_CFG 4'ha
`define TSS_CNT_MOD 4'hc
`define TSS_ID_TRBL 16'h4554
`define TSS_ID_RST 16'h4552
`define TSS_ZONE 16'h0001
// ************************************************
// Register map
// ************************************************
`define TSS_ADDR_CTRL 4'h0
`define TSS_ADDR_ACCT 4'h4
`define TSS_ADDR_POLL 4'h8
`define TSS_ADDR_STAT 4'hc
`define TSS_CTRL_PAR_EN 3
`define TSS_CTRL_PAR_EVEN 4
`define TSS_CTRL_STOP1 5
`define TSS_CTRL_FLOW 6
`define TSS_CTRL_RST 7'h05
`define TSS_ACCT_RST 24'hffffff
`define TSS_ACCT_ZERO 24'h000000
`define TSS_POLL_RST 16'h03e8
// ************************************************
// Link rates
// ************************************************
`define TSS_BAUD1 9600
`define TSS_BAUD2 19200
`define TSS_BAUD3 38400
`define TSS_BAUD4 57600
`define TSS_BAUD5 115200
`endif

// File: tss_pkg.sv
package tss_pkg;
  typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_PAUSE} tss_flash_st_t;
  typedef enum logic [1:0] {BL_IDLE, BL_ON, BL_OFF} tss_blink_st_t;
endpackage

// File: tss_flash.sv
`timescale 1ns/100ps
`include "tss_defs.svh"
module tss_flash
  import tss_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Control
  input wire logic tick_i,
  input wire logic [3:0] count_i,
  // LED
  output logic led_o
);
  tss_flash_st_t state;
  logic [3:0] left;
  logic [15:0] ms;

  // ************************************************
  // Flash group sequencer
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= FL_IDLE;
      left <= 4'h0;
      ms <= 16'h0000;
      led_o <= 1'b0;
    end else if (count_i == 4'h0) begin
      state <= FL_IDLE;
      led_o <= 1'b0;
      ms <= 16'h0000;
    end else begin
      unique case (state)
        FL_IDLE: begin
          state <= FL_ON;
          left <= count_i;
          ms <= 16'h0000;
          led_o <= 1'b1;
        end
        FL_ON: if (tick_i) begin
          if (ms == `TSS_FLASH_ON_MS - 16'h0001) begin
            led_o <= 1'b0;
            ms <= 16'h0000;
            left <= left - 4'h1;
            state <= (left == 4'h1) ? FL_PAUSE : FL_OFF;
          end else begin
            ms <= ms + 16'h0001;
          end
        end
        FL_OFF: if (tick_i) begin
          if (ms == `TSS_FLASH_OFF_MS - 16'h0001) begin
            led_o <= 1'b1;
            ms <= 16'h0000;
            state <= FL_ON;
          end else begin
            ms <= ms + 16'h0001;
          end
        end
        FL_PAUSE: if (tick_i) begin
          if (ms == `TSS_PAUSE_MS - 16'h0001) begin
            state <= FL_IDLE;
          end else begin
            ms <= ms + 16'h0001;
          end
        end
      endcase
    end
  end

  flash_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    count_i == 4'h0 |=> !led_o) else $error("Trouble LED lit with no trouble");
endmodule

// File: tss_blink.sv
`timescale 1ns/100ps
`include "tss_defs.svh"
module tss_blink
  import tss_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Events
  input wire logic tick_i,
  input wire logic once_i,
  input wire logic twice_i,
  input wire logic fault_i,
  // LED
  output logic led_o
);
  tss_blink_st_t state;
  logic [1:0] pend;
  logic [15:0] ms;
  logic take;
  logic [2:0] next_pend;

  assign take = (state == BL_IDLE) && (pend != 2'h0);
  always_comb begin
    next_pend = {1'b0, pend} - {2'h0, take} + {2'h0, once_i} + {1'b0, twice_i, 1'b0};
    if (next_pend > 3'h3) begin
      next_pend = 3'h3;
    end
  end

  // ************************************************
  // Blink sequencer
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= BL_IDLE;
      pend <= 2'h0;
      ms <= 16'h0000;
    end else begin
      pend <= next_pend[1:0];
      unique case (state)
        BL_IDLE: if (take) begin
          state <= BL_ON;
          ms <= 16'h0000;
        end
        BL_ON, BL_OFF: if (tick_i) begin
          if (ms == `TSS_BLINK_MS - 16'h0001) begin
            ms <= 16'h0000;
            state <= (state == BL_ON) ? BL_OFF : BL_IDLE;
          end else begin
            ms <= ms + 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_o <= 1'b0;
    end else begin
      led_o <= fault_i || (state == BL_ON);
    end
  end

  conn_fault_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    fault_i |=> led_o) else $error("Connection LED dark during link fault");
  conn_quiet_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !fault_i && state == BL_IDLE && pend == 2'h0 |=> !led_o) else $error("Connection LED lit while idle");
endmodule

// File: tss_far_model.sv
`timescale 1ns/100ps
// ************************************************
// Panel and hub stand-in
// ************************************************
module tss_far_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Panel side
  input wire logic poll_i,
  input wire logic answer_i,
  input wire logic slow_i,
  output logic reply_o,
  output int misses_o,
  // Hub side
  output logic ready_o
);
  logic [3:0] dly;
  logic [1:0] ph;
  // Poll replies, prompt or slow
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly <= 4'h0;
      reply_o <= 1'b0;
      misses_o <= 0;
    end else begin
      reply_o <= (dly == 4'h1);
      if (poll_i && answer_i) begin
        dly <= slow_i ? 4'h8 : 4'h2;
      end else if (dly != 4'h0) begin
        dly <= dly - 4'h1;
      end
      if (reply_o) begin
        misses_o <= 0;
      end else if (poll_i) begin
        misses_o <= misses_o + 1;
      end
    end
  end
  // Hub takes one event in four cycles
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      ready_o <= (ph == 2'h3);
    end
  end
endmodule

// File: testbench.sv
`timescale 1ns/100ps
`include "tss_defs.svh"
// ************************************************
// Bench
// ************************************************
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic clock_i = 0, rst_n_i = 0, read_i = 0, write_i = 0, link_fault_i = 0, jump = 1, answer = 1, slow = 0, ack = 0;
  logic [2:0] pls = 0;
  logic [3:0] address_i = 0;
  logic [31:0] writedata_i = 0, readdata_o, c, seed = 14;
  logic waitrequest_o, poll_o, reply, evt_valid_o, evt_ready, evt_restore_o, factory_restore_o;
  logic trouble_led_o, conn_led_o, parity_en_o, parity_even_o, stop_one_o, flow_en_o;
  logic [15:0] evt_id_o, evt_zone_o, baud_div_o;
  logic [23:0] evt_account_o;
  logic [63:0] rq[$], rx;
  logic [56:0] eq[$], ev;
  int misses, n, num_errors = 0, n_checks = 0, restores = 0;
  int rate[5] = '{9600, 19200, 38400, 57600, 115200};
  always #4 clock_i = ~clock_i;
  tss_top #(.TICK_CYCLES(4)) i_tss_top (.clock_i, .rst_n_i, .address_i, .read_i, .write_i, .writedata_i,
    .byteenable_i(4'hf), .readdata_o, .waitrequest_o, .poll_o, .poll_reply_i(reply), .prog_fail_i(pls[0]),
    .prog_ok_i(pls[1]), .tx_msg_i(pls[2]), .ack_i(ack), .link_fault_i, .evt_valid_o,
    .evt_ready_i(evt_ready), .evt_restore_o, .evt_id_o, .evt_zone_o, .evt_account_o, .baud_div_o,
    .parity_en_o, .parity_even_o, .stop_one_o, .flow_en_o, .factory_default_jumper_i(jump),
    .factory_restore_o, .trouble_led_o, .conn_led_o);
  tss_far_model i_tss_far_model (.clock_i, .rst_n_i, .poll_i(poll_o), .answer_i(answer), .slow_i(slow),
    .reply_o(reply), .misses_o(misses), .ready_o(evt_ready));
  task finish_test;
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m = '1);
    int k;
    if (rd) rq.push_back({m, d});
    @(posedge clock_i);
    address_i <= a;
    read_i <= rd;
    write_i <= !rd;
    writedata_i <= d;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (waitrequest_o !== 1'b0 && k < 50);
    if (waitrequest_o !== 1'b0) begin
      num_errors++;
      finish_test;
    end
    read_i <= 0;
    write_i <= 0;
  endtask
  task automatic pulse(input int b);
    @(posedge clock_i);
    if (b == 3) ack <= 1; else pls[b] <= 1;
    @(posedge clock_i);
    if (b == 3) ack <= 0; else pls[b] <= 0;
  endtask
  task automatic waitm(input int v);
    int k;
    for (k = 0; k < 500 && misses != v; k++) @(negedge clock_i);
    if (k == 500) begin
      num_errors++;
      finish_test;
    end
  endtask
  task automatic rises(input logic tl, input int cyc, output int r);
    logic p;
    r = 0;
    p = tl ? trouble_led_o : conn_led_o;
    repeat (cyc) begin
      @(negedge clock_i);
      if ((tl ? trouble_led_o : conn_led_o) === 1'b1 && p !== 1'b1) r++;
      p = tl ? trouble_led_o : conn_led_o;
    end
  endtask
  // Flash count of one group framed by long dark pauses
  task automatic group(output int r);
    int g;
    r = 0;
    g = 0;
    repeat (40000) begin
      @(negedge clock_i);
      if (trouble_led_o !== 1'b1) g++;
      else if (g > 0) begin
        if (g >= 2000 && r > 0) break;
        r = (g >= 2000) ? 1 : (r > 0 ? r + 1 : 0);
        g = 0;
      end
    end
  endtask
  // Scoreboards for reads and hub events
  always @(negedge clock_i) begin
    if (read_i && waitrequest_o === 1'b0) begin
      rx = rq.pop_front();
      `CHK(readdata_o & rx[63:32], rx[31:0])
    end
    if (evt_valid_o === 1'b1 && evt_ready === 1'b1) begin
      ev = eq.size() ? eq.pop_front() : 'x;
      `CHK({evt_restore_o, evt_id_o, evt_zone_o, evt_account_o}, ev)
    end
    if (factory_restore_o === 1'b1) restores++;
  end
  initial begin
    repeat (100000) @(posedge clock_i);
    num_errors++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1;
    repeat (16) begin
      repeat (400) @(negedge clock_i);
      `CHK(conn_led_o, trouble_led_o)
    end
    repeat (2000) @(posedge clock_i);
    `CHK(restores, 1)
    jump <= 0;
    bus(1, `TSS_ADDR_CTRL, 32'h5);
    bus(1, `TSS_ADDR_ACCT, 32'hffffff);
    bus(1, 4'h2, 32'h0);
    for (int i = 1; i <= 5; i++) begin
      c = (xs() & 32'h78) | i;
      bus(0, `TSS_ADDR_CTRL, c);
      bus(1, `TSS_ADDR_CTRL, c);
      @(negedge clock_i);
      `CHK(baud_div_o, 16'(125000000 / rate[i - 1]))
      `CHK({parity_en_o, parity_even_o, stop_one_o, flow_en_o}, {c[3], c[4], c[5], c[6]})
    end
    bus(0, `TSS_ADDR_POLL, 32'h3);
    jump <= 1;
    repeat (60) @(posedge clock_i);
    bus(1, `TSS_ADDR_STAT, 32'h0c04, 32'h0f07);
    pulse(0);
    bus(1, `TSS_ADDR_STAT, 32'h0a06, 32'h0f07);
    bus(0, `TSS_ADDR_ACCT, 32'h123456);
    answer <= 0;
    eq.push_back({1'b0, 16'h4554, 16'h0001, 24'h123456});
    waitm(6);
    bus(1, `TSS_ADDR_STAT, 32'h0a52, 32'h0f77);
    waitm(7);
    repeat (4) @(posedge clock_i);
    bus(1, `TSS_ADDR_STAT, 32'h0263, 32'h0f77);
    group(n);
    `CHK(n, 2)
    @(posedge clock_i);
    eq.push_back({1'b1, 16'h4552, 16'h0001, 24'h123456});
    slow <= 1;
    answer <= 1;
    waitm(0);
    repeat (3) @(posedge clock_i);
    bus(1, `TSS_ADDR_STAT, 32'h0a02, 32'h0f77);
    pulse(1);
    bus(1, `TSS_ADDR_STAT, 32'h0, 32'h0f77);
    rises(1, 3000, n);
    `CHK(n, 0)
    rises(0, 1000, n);
    `CHK(n, 0)
    pulse(2);
    rises(0, 1500, n);
    `CHK(n, 1)
    pulse(3);
    rises(0, 1500, n);
    `CHK(n, 2)
    @(posedge clock_i);
    link_fault_i <= 1;
    repeat (3) @(posedge clock_i);
    rises(0, 100, n);
    `CHK(conn_led_o, 1'b1)
    `CHK(n, 0)
    `CHK(restores, 1)
    `CHK(eq.size(), 0)
    finish_test;
  end
endmodule
